// *** rtl/short_diag_pkg.sv ***
// Function
// - Enable bits at 0x55: bit 1 input one, bit 3 input two, reset masked.
// - A detected short event sets that input's status flag.
// - Status flags stay set until software clears them.
// - Flags readable at 0x53 bits 1 and 3; writes do not change them.
// - Event means comparator reports pin voltage above the threshold.
// - Writing 1 to clear bit at 0x54 bit 1 or 3 clears that flag, unless that input's event is detected in the same cycle.
// - Clear bits write-only, self-clearing, reset 0; writing 0 does nothing.
// - A set unmasked flag asserts the interrupt request pin.
// - Two-bit drive style selector in bits 1:0 at offset 0x40.
// - Open drain: released when idle, driven low when asserted.
// - Drive low style: driven high idle, driven low when asserted.
// - Drive high style: driven low idle, driven high when asserted.
// - Style codes: 00 open drain default, 01 low, 10 high, 11 reserved.
// - Length bits 7:6 at 0x40: 3, 15, 63 crystal periods, 11 until cleared.
// - Until-cleared mode holds pin until all set unmasked flags clear.
package short_diag_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h40;
	localparam logic [7:0] ADDR_STATUS = 8'h53;
	localparam logic [7:0] ADDR_CLEAR  = 8'h54;
	localparam logic [7:0] ADDR_ENABLE = 8'h55;
	localparam int BIT_ONE   = 1;
	localparam int BIT_TWO   = 3;
	localparam int STYLE_LSB = 0;
	localparam int LEN_LSB   = 6;
	localparam logic [1:0] STYLE_OPEN_DRAIN = 2'h0;
	localparam logic [1:0] STYLE_DRIVE_LOW  = 2'h1;
	localparam logic [1:0] STYLE_DRIVE_HIGH = 2'h2;
	localparam logic [1:0] LEN_SHORT   = 2'h0;
	localparam logic [1:0] LEN_MEDIUM  = 2'h1;
	localparam logic [1:0] LEN_LONG    = 2'h2;
	localparam logic [1:0] LEN_LATCHED = 2'h3;
	localparam logic [6:0] PERIODS_SHORT  = 7'h03;
	localparam logic [6:0] PERIODS_MEDIUM = 7'h0F;
	localparam logic [6:0] PERIODS_LONG   = 7'h3F;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	typedef enum logic [1:0] {
		IRQ_IDLE  = 2'b00,
		IRQ_PULSE = 2'b01,
		IRQ_HOLD  = 2'b10,
		IRQ_WAIT  = 2'b11
	} irq_state_t;
endpackage : short_diag_pkg

// *** rtl/event_flag_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface event_flag_if;
	logic detect;
	logic clear;
	logic flag;
	modport owner (input detect, input clear, output flag);
	modport user  (output detect, output clear, input flag);
endinterface : event_flag_if
`default_nettype wire

// *** rtl/sticky_event_flag.sv ***
`timescale 1ns/100ps
`default_nettype none
module sticky_event_flag (
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	event_flag_if.owner       port
);
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port.flag <= 1'b0;
		end else if (port.detect) begin
			port.flag <= 1'b1;
		end else if (port.clear) begin
			port.flag <= 1'b0;
		end
	end
endmodule : sticky_event_flag
`default_nettype wire

// *** rtl/battery_short_diag_irq.sv ***
`timescale 1ns/100ps
`default_nettype none
module battery_short_diag_irq (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       crystal_tick_in,
	input  wire logic       monitor_one_above_in,
	input  wire logic       monitor_two_above_in,
	input  wire logic       reg_write_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	output var  logic [7:0] reg_rdata_out,
	output var  logic       irq_request_pin_out,
	output var  logic       irq_request_pin_oe_out
);
	logic [1:0]  mon_meta;
	logic [1:0]  mon_sync;
	logic [7:0]  config_reg;
	logic        short_event_one_enable;
	logic        short_event_two_enable;
	logic [6:0]  pulse_count;
	logic        pulse_done;
	logic [1:0]  pend_seen;
	short_diag_pkg::irq_state_t state;
	short_diag_pkg::irq_state_t next_state;
	short_diag_pkg::irq_state_t start_state;
	event_flag_if one_if ();
	event_flag_if two_if ();

	sticky_event_flag u_flag_one (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.port      (one_if.owner)
	);
	sticky_event_flag u_flag_two (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.port      (two_if.owner)
	);

	// Comparator outputs synchronised
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mon_meta <= 2'h0;
			mon_sync <= 2'h0;
		end else begin
			mon_meta <= {monitor_two_above_in, monitor_one_above_in};
			mon_sync <= mon_meta;
		end
	end

	wire wr_config = reg_write_in && reg_addr_in == short_diag_pkg::ADDR_CONFIG;
	wire wr_clear  = reg_write_in && reg_addr_in == short_diag_pkg::ADDR_CLEAR;
	wire wr_enable = reg_write_in && reg_addr_in == short_diag_pkg::ADDR_ENABLE;

	assign one_if.detect = mon_sync[0];
	assign two_if.detect = mon_sync[1];
	// Clear is a strobe only, never stored
	assign one_if.clear = wr_clear && reg_wdata_in[short_diag_pkg::BIT_ONE];
	assign two_if.clear = wr_clear && reg_wdata_in[short_diag_pkg::BIT_TWO];

	wire [1:0] style = config_reg[short_diag_pkg::STYLE_LSB +: 2];
	wire [1:0] len_sel = config_reg[short_diag_pkg::LEN_LSB +: 2];

	wire [1:0] pend_vec = {two_if.flag && short_event_two_enable,
		one_if.flag && short_event_one_enable};
	wire pending = |pend_vec;
	// A flag newly set or unmasked raises a fresh request
	wire fresh = |(pend_vec & ~pend_seen);
	assign start_state = (len_sel == short_diag_pkg::LEN_LATCHED)
		? short_diag_pkg::IRQ_HOLD
		: short_diag_pkg::IRQ_PULSE;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			config_reg             <= short_diag_pkg::CONFIG_RESET;
			short_event_one_enable <= 1'b0;
			short_event_two_enable <= 1'b0;
		end else begin
			if (wr_config) begin
				config_reg <= reg_wdata_in;
			end
			if (wr_enable) begin
				short_event_one_enable <= reg_wdata_in[short_diag_pkg::BIT_ONE];
				short_event_two_enable <= reg_wdata_in[short_diag_pkg::BIT_TWO];
			end
		end
	end

	// Read mux; status is read only, clear reads zero
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr_in)
			short_diag_pkg::ADDR_CONFIG: next_rdata = config_reg;
			short_diag_pkg::ADDR_STATUS: begin
				next_rdata[short_diag_pkg::BIT_ONE] = one_if.flag;
				next_rdata[short_diag_pkg::BIT_TWO] = two_if.flag;
			end
			short_diag_pkg::ADDR_ENABLE: begin
				next_rdata[short_diag_pkg::BIT_ONE] = short_event_one_enable;
				next_rdata[short_diag_pkg::BIT_TWO] = short_event_two_enable;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// Pulse length in crystal periods
	logic [6:0] pulse_limit;
	always_comb begin
		unique case (len_sel)
			short_diag_pkg::LEN_SHORT:  pulse_limit = short_diag_pkg::PERIODS_SHORT;
			short_diag_pkg::LEN_MEDIUM: pulse_limit = short_diag_pkg::PERIODS_MEDIUM;
			default:                    pulse_limit = short_diag_pkg::PERIODS_LONG;
		endcase
	end
	assign pulse_done = crystal_tick_in && (pulse_count + 7'h01 >= pulse_limit);

	// Pulse fires on a new pending condition, then waits for it to drop
	always_comb begin
		next_state = state;
		unique case (state)
			short_diag_pkg::IRQ_IDLE:
				if (pending) begin
					next_state = start_state;
				end
			short_diag_pkg::IRQ_PULSE:
				if (pulse_done) begin
					next_state = short_diag_pkg::IRQ_WAIT;
				end
			short_diag_pkg::IRQ_HOLD:
				if (!pending) begin
					next_state = short_diag_pkg::IRQ_IDLE;
				end
			short_diag_pkg::IRQ_WAIT:
				if (fresh) begin
					next_state = start_state;
				end else if (!pending) begin
					next_state = short_diag_pkg::IRQ_IDLE;
				end
		endcase
	end

	wire active = (next_state == short_diag_pkg::IRQ_PULSE)
		|| (next_state == short_diag_pkg::IRQ_HOLD);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state         <= short_diag_pkg::IRQ_IDLE;
			pulse_count   <= 7'h00;
			reg_rdata_out <= 8'h00;
			pend_seen     <= 2'h0;
		end else begin
			state         <= next_state;
			reg_rdata_out <= next_rdata;
			pend_seen     <= pend_vec;
			if (state != short_diag_pkg::IRQ_PULSE) begin
				pulse_count <= 7'h00;
			end else if (crystal_tick_in) begin
				pulse_count <= pulse_count + 7'h01;
			end
		end
	end

	// Pin drive per style
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_request_pin_out    <= 1'b0;
			irq_request_pin_oe_out <= 1'b0;
		end else begin
			unique case (style)
				short_diag_pkg::STYLE_DRIVE_LOW: begin
					irq_request_pin_out    <= !active;
					irq_request_pin_oe_out <= 1'b1;
				end
				short_diag_pkg::STYLE_DRIVE_HIGH: begin
					irq_request_pin_out    <= active;
					irq_request_pin_oe_out <= 1'b1;
				end
				default: begin
					irq_request_pin_out    <= 1'b0;
					irq_request_pin_oe_out <= active;
				end
			endcase
		end
	end
endmodule : battery_short_diag_irq
`default_nettype wire

// *** verification/irq_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
	input  wire logic pin_in,
	input  wire logic oe_in,
	output var  logic level_out
);
	// Pull-up holds the released line high
	assign level_out = oe_in ? pin_in : 1'b1;
endmodule : irq_host_model
`default_nettype wire

// *** verification/battery_short_diag_irq_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module battery_short_diag_irq_assertions (
	input wire logic       clk_in,
	input wire logic       resetn_in,
	input wire logic       crystal_tick_in,
	input wire logic       reg_write_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       irq_request_pin_out,
	input wire logic       irq_request_pin_oe_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] cfg;
	logic [7:0] en;
	logic [6:0] ticks;
	wire act = cfg[1:0] == 2'h1 ? !irq_request_pin_out :
		cfg[1:0] == 2'h2 ? irq_request_pin_out : irq_request_pin_oe_out;
	wire [6:0] lim = cfg[7:6] == 2'h0 ? 7'h03 :
		cfg[7:6] == 2'h1 ? 7'h0F : 7'h3F;
	// Mirrors of the written control bytes
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg <= 8'h00;
			en <= 8'h00;
		end else if (reg_write_in) begin
			if (reg_addr_in == 8'h40) cfg <= reg_wdata_in;
			if (reg_addr_in == 8'h55) en <= reg_wdata_in;
		end
	end
	// Crystal ticks seen while the pin is active
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) ticks <= 7'h00;
		else ticks <= act ? ticks + 7'(crystal_tick_in) : 7'h00;
	end
	sequence s_pulse_end;
		$fell(act) && cfg[7:6] != 2'h3 && cfg == $past(cfg, 2);
	endsequence
	sequence s_quiet_bus;
		!(reg_write_in || $past(reg_write_in) || $past(reg_write_in, 2));
	endsequence
	a_clear_reads_zero: assert property (reg_addr_in == 8'h54 |=>
		reg_rdata_out == 8'h00) else $error("clear register reads nonzero");
	a_cfg_read_back: assert property (reg_addr_in == 8'h40 |=>
		reg_rdata_out == $past(cfg)) else $error("config readback wrong");
	a_od_never_high: assert property (cfg[1:0] != 2'h1 &&
		cfg[1:0] != 2'h2 && cfg == $past(cfg) |->
		!(irq_request_pin_oe_out && irq_request_pin_out))
		else $error("open drain pin driven high");
	a_push_pull_on: assert property ((cfg[1:0] == 2'h1 ||
		cfg[1:0] == 2'h2) && cfg == $past(cfg) |-> irq_request_pin_oe_out)
		else $error("push pull pin not driven");
	a_reset_idle: assert property ($rose(resetn_in) |-> !act)
		else $error("pin active after reset");
	a_pulse_len: assert property (s_pulse_end |-> ticks == lim)
		else $error("pulse length wrong");
	a_latched_hold: assert property (act && cfg[7:6] == 2'h3
		##0 s_quiet_bus |=> act) else $error("latched pin dropped");
	a_rise_needs_enable: assert property ($rose(act) &&
		cfg == $past(cfg, 2) |-> $past(en[1] | en[3]))
		else $error("pin raised while masked");
endmodule : battery_short_diag_irq_assertions
`default_nettype wire

// *** verification/battery_short_diag_irq_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module battery_short_diag_irq_test;
	logic clk_in = 0, resetn_in = 0, tick = 0, mon1 = 0, mon2 = 0, wr = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	logic req = 0, rv = 0;
	logic [1:0] s;
	logic [2:0] idle, mk;
	int err_total = 0, tests_run = 0, cyc = 0;
	wire logic [7:0] rdata;
	wire logic pin, oe, lvl;
	battery_short_diag_irq dut_u (.clk_in, .resetn_in, .crystal_tick_in(tick),
		.monitor_one_above_in(mon1), .monitor_two_above_in(mon2),
		.reg_write_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .irq_request_pin_out(pin),
		.irq_request_pin_oe_out(oe));
	irq_host_model host_u (.pin_in(pin), .oe_in(oe), .level_out(lvl));
	initial forever #50 clk_in = !clk_in;
	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	task automatic step(int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask : step
	task automatic wrt(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		step(1);
		wr = 0;
		step(1);
	endtask : wrt
	// Note an expectation; the monitor compares two edges later
	task automatic chk(logic [16:0] x);
		exp_q.push_back(x);
		req = 1;
		step(1);
		req = 0;
		step(1);
	endtask : chk
	task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] x);
		addr = a;
		chk({1'b0, m, x});
	endtask : rd
	task automatic pin_chk(logic [2:0] m, logic [2:0] x);
		chk({1'b1, 5'h00, m, 5'h00, x});
	endtask : pin_chk
	always @(posedge clk_in) begin
		if (rv) begin
			e = exp_q.pop_front();
			tests_run++;
			if (((e[16] ? {5'h00, oe, pin, lvl} : rdata) & e[15:8]) !== e[7:0])
			begin
				err_total++;
				$display("MISMATCH %0t got %h %b%b%b want %h", $time, rdata, oe,
					pin, lvl, e);
			end
		end
		rv = req;
	end
	always begin
		wait (resetn_in);
		step(1 + $urandom_range(3));
		tick = 1;
		step(1);
		tick = 0;
	end
	always @(posedge clk_in) begin
		if (++cyc > 20000) begin
			err_total++;
			$display("MISMATCH %0t run timed out", $time);
			end_sim();
		end
	end
	initial begin
		void'($urandom(32'hce14));
		step(4);
		resetn_in = 1;
		step(1);
		rd(8'h55, 8'h0A, 8'h00);
		rd(8'h40, 8'hFF, 8'h00);
		rd(8'h53, 8'h0A, 8'h00);
		pin_chk(3'h7, 3'h1);
		$display("test reset done");
		mon1 = 1;
		step(2 + $urandom_range(4));
		mon1 = 0;
		step(4);
		rd(8'h53, 8'h0A, 8'h02);
		pin_chk(3'h7, 3'h1);
		wrt(8'h53, 8'h00);
		wrt(8'h54, 8'h00);
		wrt(8'h20, 8'($urandom));
		rd(8'h20, 8'hFF, 8'h00);
		rd(8'h53, 8'h0A, 8'h02);
		wrt(8'h55, 8'h0A);
		pin_chk(3'h7, 3'h4);
		rd(8'h55, 8'h0A, 8'h0A);
		step(40);
		pin_chk(3'h5, 3'h1);
		$display("test masked event done");
		mon2 = 1;
		step(4);
		pin_chk(3'h7, 3'h4);
		wrt(8'h54, 8'h0A);
		rd(8'h53, 8'h0A, 8'h08);
		mon2 = 0;
		step(3);
		wrt(8'h54, 8'h08);
		rd(8'h53, 8'h0A, 8'h00);
		$display("test clear done");
		for (int i = 0; i < 4; i++) begin
			s = 2'(i);
			idle = {s == 1 || s == 2, s == 1, s != 2};
			mk = {1'b1, s == 1 || s == 2, 1'b1};
			wrt(8'h40, {2'(i), 4'h0, s});
			rd(8'h40, 8'hFF, {2'(i), 4'h0, s});
			pin_chk(mk, idle);
			mon1 = 1;
			step(3);
			mon1 = 0;
			step(1);
			pin_chk(3'h7, {1'b1, s == 2, s == 2});
			step(400);
			pin_chk(mk, i == 3 ? {1'b1, 2'h0} : idle);
			wrt(8'h54, 8'h02);
			pin_chk(mk, idle);
		end
		$display("test styles done");
		end_sim();
	end
endmodule : battery_short_diag_irq_test
bind battery_short_diag_irq battery_short_diag_irq_assertions chk_u (.clk_in,
	.resetn_in, .crystal_tick_in, .reg_write_in, .reg_addr_in, .reg_wdata_in,
	.reg_rdata_out, .irq_request_pin_out, .irq_request_pin_oe_out);
`default_nettype wire
